// ---- hdl/hbc_pkg.sv ----
// shared constants and types of the h-bridge serial control block
package hbc_pkg;
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          SYNC_W        = 23;
	// serial word layout
	localparam int          SPI_BITS      = 16;
	localparam int          FAULT_W       = 14;
	localparam int          SPI_ADDR_MSB  = 15;
	localparam int          SPI_ADDR_LSB  = 14;
	localparam logic [1:0]  SPI_REG_FAULT = 2'h0;
	localparam logic [1:0]  SPI_REG_CFG   = 2'h1;
	localparam logic [1:0]  SPI_REG_MASK  = 2'h2;
	localparam int          SLEW_W        = 3;
	localparam logic [2:0]  SLEW_RST      = 3'h2;
	localparam logic [13:0] FMASK_RST     = 14'h3fff;
	// dead time per slew step
	localparam int          DEAD_BASE_NS  = 200;
	localparam int          DEAD_BASE_CYC = (DEAD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// register bus map
	localparam int          AXI_AW        = 4;
	localparam logic [3:0]  AXI_STATUS    = 4'h0;
	localparam logic [3:0]  AXI_IRQ_STAT  = 4'h4;
	localparam logic [3:0]  AXI_IRQ_MASK  = 4'h8;
	localparam logic [3:0]  AXI_SPI_CFG   = 4'hc;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// interrupt bits
	localparam int          IRQ_W         = 3;
	localparam int          IRQ_WORD      = 0;
	localparam int          IRQ_FAULT     = 1;
	localparam int          IRQ_MODE      = 2;
	localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;
	typedef enum logic [2:0] {
		HBC_SLEEP   = 3'b001,
		HBC_STANDBY = 3'b010,
		HBC_RUN     = 3'b100
	} hbc_mode_e;
endpackage : hbc_pkg

// ---- hdl/hbc_bridge_drv.sv ----
// gate drive of both half-bridges with break-before-make dead time
`timescale 1ns/100ps
module hbc_bridge_drv
	import hbc_pkg::*;
#(
	parameter int DEAD_W = 8
)(
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// control
	input  wire logic                      run,
	input  wire logic                      dir_a,
	input  wire logic                      dir_b,
	input  wire logic                      pwm,
	input  wire logic [hbc_pkg::SLEW_W-1:0] slew,
	// switches
	output logic                           hs_a,
	output logic                           ls_a,
	output logic                           hs_b,
	output logic                           ls_b
);
	import hbc_pkg::*;

	logic [3:0]        sw_q;
	logic [DEAD_W-1:0] dead_q;

	function automatic logic [DEAD_W-1:0] dead_len(input logic [SLEW_W-1:0] s);
		dead_len = DEAD_W'(DEAD_BASE_CYC) * (DEAD_W'(s) + DEAD_W'(1));
	endfunction : dead_len

	// order {hs_a, ls_a, hs_b, ls_b}; pwm steered to one low side
	wire       fwd    = dir_a & ~dir_b;
	wire       rev    = ~dir_a & dir_b;
	wire       brake  = dir_a & dir_b;
	wire [3:0] tgt    = run ? {fwd | brake, rev & pwm, rev | brake, fwd & pwm} : 4'h0;
	wire       go_off = |(sw_q & ~tgt);

	// off at once, on only after the dead time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sw_q   <= 4'h0;
			dead_q <= '0;
		end
		else if (go_off)
		begin
			sw_q   <= sw_q & tgt;
			dead_q <= dead_len(slew);
		end
		else if (dead_q != '0)
			dead_q <= dead_q - DEAD_W'(1);
		else
			sw_q <= tgt;
	end

	assign hs_a = sw_q[3];
	assign ls_a = sw_q[2];
	assign hs_b = sw_q[1];
	assign ls_b = sw_q[0];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_no_cross_a: assert property (!(hs_a && ls_a))
		else $error("half-bridge a shoot-through");
	a_no_cross_b: assert property (!(hs_b && ls_b))
		else $error("half-bridge b shoot-through");
	a_gap_hs_a: assert property ($rose(hs_a) |-> !$past(ls_a, 1) && !$past(ls_a, 2))
		else $error("no dead time before high side a");
	a_idle_off: assert property (!run |=> sw_q == 4'h0)
		else $error("switch on while not running");
	a_fwd_route: assert property (run && fwd && dead_q == '0 && !go_off |=> hs_a && ls_b == $past(pwm))
		else $error("forward drive not routed");
endmodule : hbc_bridge_drv

// ---- hdl/hbc_top.sv ----
// h-bridge control: serial slave, mode logic, fault flag, register bus
//
// Summary of operation
// - enable low puts all four switches off and enters sleep.
// - enable high allows normal bridge operation.
// - disable high puts all switches off in standby, not sleep; the code enters sleep instead while enable is low.
// - disable low does not inhibit the bridge outputs.
// - high and low side of one half-bridge never on together.
// - direction inputs route pwm to one of the two low sides.
// - a direction change never lets both switches of a half conduct.
// - switching times follow the slew setting held in the serial register.
// - slave only, daisy-chainable on a shared select.
// - sample input on serial clock fall, update output on rise.
// - outgoing word goes most significant bit first.
// - after the sixteen bits of the addressed register the output echoes the received input.
// - serial output is high impedance unless select is low.
// - input accepted only while select low, msb first from master.
// - select rising applies the received word.
// - select falling loads the register addressed last time.
// - fault flag pulls low when any unmasked fault is present.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module hbc_top
	import hbc_pkg::*;
(
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write
	input  wire logic [hbc_pkg::AXI_AW-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read
	input  wire logic [hbc_pkg::AXI_AW-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// interrupt
	output logic                             irq,
	// serial link
	input  wire logic                        sclk_in,
	input  wire logic                        cs_n_in,
	input  wire logic                        mosi_in,
	output logic                             miso_o,
	output logic                             miso_oe,
	// bridge control pins
	input  wire logic                        chip_enable_in,
	input  wire logic                        output_disable_in,
	input  wire logic                        direction_ctrl_a,
	input  wire logic                        direction_ctrl_b,
	input  wire logic                        pwm_in,
	// faults
	input  wire logic [hbc_pkg::FAULT_W-1:0] fault_src,
	input  wire logic                        fault_flag_n_i,
	output logic                             fault_flag_n_o,
	output logic                             fault_flag_n_oe,
	// bridge switches and analog settings
	output logic                             half_bridge_out_a_hs,
	output logic                             half_bridge_out_a_ls,
	output logic                             half_bridge_out_b_hs,
	output logic                             half_bridge_out_b_ls,
	output logic [hbc_pkg::SLEW_W-1:0]       slew_sel,
	output logic                             sleep_o,
	output logic                             standby_o
);
	import hbc_pkg::*;

	// input synchronisers
	logic [SYNC_W-1:0]  meta_q;
	logic [SYNC_W-1:0]  sync_q;
	logic               sclk_prev_q;
	logic               cs_prev_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= {{(SYNC_W-FAULT_W-1){1'b0}}, 1'b1, {FAULT_W{1'b0}}};
			sync_q <= {{(SYNC_W-FAULT_W-1){1'b0}}, 1'b1, {FAULT_W{1'b0}}};
		end
		else
		begin
			meta_q <= {pwm_in, direction_ctrl_b, direction_ctrl_a, output_disable_in,
				chip_enable_in, fault_flag_n_i, sclk_in, mosi_in, cs_n_in, fault_src};
			sync_q <= meta_q;
		end
	end

	wire [FAULT_W-1:0] flt_s   = sync_q[FAULT_W-1:0];
	wire               cs_s    = sync_q[14];
	wire               mosi_s  = sync_q[15];
	wire               sclk_s  = sync_q[16];
	wire               flag_s  = sync_q[17];
	wire               en_s    = sync_q[18];
	wire               dis_s   = sync_q[19];
	wire               dira_s  = sync_q[20];
	wire               dirb_s  = sync_q[21];
	wire               pwm_s   = sync_q[22];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end
		else
		begin
			sclk_prev_q <= sclk_s;
			cs_prev_q   <= cs_s;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_s;
	wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_s;
	wire cs_fall   = ~cs_s & cs_prev_q;
	wire cs_rise   = cs_s & ~cs_prev_q;

	// serial register file
	logic [SPI_BITS-1:0] shift_q;
	logic [3:0]          cnt_q;
	logic                full_q;
	logic                miso_q;
	logic                miso_oe_q;
	logic [1:0]          prev_addr_q;
	logic [SLEW_W-1:0]   slew_q;
	logic [FAULT_W-1:0]  fmask_q;
	logic [FAULT_W-1:0]  fault_q;
	logic                flag_act_q;
	hbc_mode_e           mode_q;
	hbc_mode_e           mode_d;

	wire                flag_act = |(fault_q & fmask_q);
	wire [SPI_BITS-1:0] rd_fault = {flag_act, mode_q == HBC_STANDBY, fault_q};
	wire [SPI_BITS-1:0] rd_cfg   = {{(SPI_BITS-SLEW_W){1'b0}}, slew_q};
	wire [SPI_BITS-1:0] rd_mask  = {2'b00, fmask_q};
	wire [SPI_BITS-1:0] rd_word  = (prev_addr_q == SPI_REG_CFG)  ? rd_cfg :
	                               (prev_addr_q == SPI_REG_MASK) ? rd_mask :
	                               (prev_addr_q == SPI_REG_FAULT) ? rd_fault : '0;
	wire                apply    = cs_rise & full_q & (cnt_q == 4'h0);
	wire [1:0]          w_addr   = shift_q[SPI_ADDR_MSB:SPI_ADDR_LSB];
	wire [FAULT_W-1:0]  w_data   = shift_q[FAULT_W-1:0];
	wire [FAULT_W-1:0]  f_clr    = (apply && w_addr == SPI_REG_FAULT) ? w_data : '0;

	// shift path: addressed register word out first, then the input wraps round
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shift_q <= '0;
			cnt_q   <= 4'h0;
			full_q  <= 1'b0;
			miso_q  <= 1'b0;
		end
		else if (cs_fall)
		begin
			shift_q <= rd_word;
			cnt_q   <= 4'h0;
			full_q  <= 1'b0;
			miso_q  <= rd_word[SPI_BITS-1];
		end
		else if (sclk_fall)
		begin
			shift_q <= {shift_q[SPI_BITS-2:0], mosi_s};
			cnt_q   <= cnt_q + 4'h1;
			if (cnt_q == 4'hf)
				full_q <= 1'b1;
		end
		else if (sclk_rise)
			miso_q <= shift_q[SPI_BITS-1];
	end

	// settings written at select rise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev_addr_q <= SPI_REG_FAULT;
			slew_q      <= SLEW_RST;
			fmask_q     <= FMASK_RST;
		end
		else if (apply)
		begin
			prev_addr_q <= w_addr;
			if (w_addr == SPI_REG_CFG)
				slew_q <= w_data[SLEW_W-1:0];
			if (w_addr == SPI_REG_MASK)
				fmask_q <= w_data;
		end
	end

	// faults latch; a new fault wins over a clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault_q    <= '0;
			flag_act_q <= 1'b0;
			miso_oe_q  <= 1'b0;
		end
		else
		begin
			fault_q    <= (fault_q & ~f_clr) | flt_s;
			flag_act_q <= flag_act;
			miso_oe_q  <= ~cs_s;
		end
	end

	// operating mode
	always_comb
	begin
		case (1'b1)
			!en_s:   mode_d = HBC_SLEEP;
			dis_s:   mode_d = HBC_STANDBY;
			default: mode_d = HBC_RUN;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_q <= HBC_SLEEP;
		else
			mode_q <= mode_d;
	end

	hbc_bridge_drv u_drv (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (mode_q == HBC_RUN),
		.dir_a   (dira_s),
		.dir_b   (dirb_s),
		.pwm     (pwm_s),
		.slew    (slew_q),
		.hs_a    (half_bridge_out_a_hs),
		.ls_a    (half_bridge_out_a_ls),
		.hs_b    (half_bridge_out_b_hs),
		.ls_b    (half_bridge_out_b_ls)
	);

	assign miso_o          = miso_q;
	assign miso_oe         = miso_oe_q;
	assign fault_flag_n_o  = 1'b0;
	assign fault_flag_n_oe = flag_act_q;
	assign slew_sel        = slew_q;
	assign sleep_o         = (mode_q == HBC_SLEEP);
	assign standby_o       = (mode_q == HBC_STANDBY);

	// register bus slave
	logic [AXI_AW-1:0] awaddr_q;
	logic              aw_got_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              w_got_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_mask_q;

	function automatic logic known_addr(input logic [AXI_AW-1:0] a);
		known_addr = (a == AXI_STATUS) || (a == AXI_IRQ_STAT) ||
		             (a == AXI_IRQ_MASK) || (a == AXI_SPI_CFG);
	endfunction : known_addr

	wire              do_wr   = aw_got_q & w_got_q & ~bvalid_q;
	wire              lane0   = do_wr & wstrb_q[0];
	wire [IRQ_W-1:0]  irq_clr = (lane0 && awaddr_q == AXI_IRQ_STAT) ? wdata_q[IRQ_W-1:0] : '0;
	wire              new_flt = |(flt_s & ~fault_q);
	wire [IRQ_W-1:0]  irq_ev  = {mode_d != mode_q, new_flt, apply};
	wire [31:0]       rd_stat = {13'h0000, miso_oe_q, flag_s, mode_q, fault_q};
	wire [31:0]       rd_cfgw = {2'b00, fmask_q, 13'h0000, slew_q};
	wire [31:0]       rd_bus  = (s_axi_araddr == AXI_STATUS)   ? rd_stat :
	                            (s_axi_araddr == AXI_IRQ_STAT) ? {29'h0, irq_stat_q} :
	                            (s_axi_araddr == AXI_IRQ_MASK) ? {29'h0, irq_mask_q} :
	                            (s_axi_araddr == AXI_SPI_CFG)  ? rd_cfgw : 32'h0000_0000;

	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready  = ~w_got_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_q <= '0;
			aw_got_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			w_got_q  <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q <= s_axi_awaddr;
				aw_got_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
			end
			if (do_wr)
			begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= known_addr(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= rd_bus;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// sticky events, set beats write-one-to-clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
			if (lane0 && awaddr_q == AXI_IRQ_MASK)
				irq_mask_q <= wdata_q[IRQ_W-1:0];
		end
	end

	assign irq           = |(irq_stat_q & irq_mask_q);
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_miso_hiz_idle: assert property (cs_s |=> !miso_oe)
		else $error("serial output driven while deselected");
	a_sleep_entry: assert property (!en_s |=> sleep_o ##1 !half_bridge_out_a_hs && !half_bridge_out_b_hs)
		else $error("sleep not entered with switches off");
	a_standby_entry: assert property (en_s && dis_s |=> standby_o && !sleep_o ##1 !half_bridge_out_b_ls)
		else $error("standby not entered");
	a_run_entry: assert property (en_s && !dis_s |=> mode_q == HBC_RUN)
		else $error("run not entered");
	a_first_bit: assert property (cs_fall |=> miso_o == $past(rd_word[SPI_BITS-1]))
		else $error("first output bit not from addressed register");
	a_sample_fall: assert property (sclk_fall && !cs_fall |=> shift_q[0] == $past(mosi_s))
		else $error("input not sampled on clock fall");
	a_echo_rise: assert property (sclk_rise && !cs_fall |=> miso_o == $past(shift_q[SPI_BITS-1]))
		else $error("output not updated on clock rise");
	a_apply_slew: assert property (apply && w_addr == SPI_REG_CFG |=> slew_sel == $past(w_data[SLEW_W-1:0]))
		else $error("slew setting not applied at select rise");
	a_flag_low: assert property (flag_act |=> fault_flag_n_oe && !fault_flag_n_o)
		else $error("fault flag not pulled low");
	a_irq_sticky: assert property (irq_ev != '0 |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
		else $error("interrupt event not latched");

	c_word_applied: cover property (apply);
	c_echo_phase: cover property (full_q && sclk_rise);
	c_sleep_entry: cover property (mode_q == HBC_RUN ##1 mode_q == HBC_SLEEP);
	c_bus_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : hbc_top

// ---- tb/hbc_spi_master.sv ----
// serial master and pwm source facing the h-bridge control block
`timescale 1ns/100ps
module hbc_spi_master
(
	// serial link
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso,
	// pwm drive
	output logic      pwm
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		pwm  = 1'b0;
	end

	task automatic set_pwm(input logic v);
		pwm <= v;
	endtask : set_pwm

	// low nbits of tx go out msb first; clock idles low outside frames
	task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		int i;
		rx = '0;
		#37 cs_n = 1'b0;
		mosi = tx[nbits-1];
		#400;
		for (i = nbits - 1; i >= 0; i--)
		begin
			sclk = 1'b1;
			if (i != nbits - 1)
				mosi = tx[i];
			#400 sclk = 1'b0;
			rx = {rx[30:0], miso};
			#400;
		end
		cs_n = 1'b1;
		mosi = ~mosi;
		#400;
	endtask : xfer
endmodule : hbc_spi_master

// ---- tb/test_hbridge_spi_control.sv ----
// self-checking bench of the h-bridge serial control block
`timescale 1ns/100ps
module test_hbridge_spi_control;
	import hbc_pkg::*;
	logic               aclk = 1'b0;
	logic               aresetn = 1'b0;
	logic [3:0]         s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
	logic [31:0]        s_axi_wdata = '0, s_axi_rdata, rd, rx;
	logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic               sclk_in, cs_n_in, mosi_in, miso_o, miso_oe, pwm_in, fault_flag_n_o, fault_flag_n_oe;
	logic               chip_enable_in = 0, output_disable_in = 0, direction_ctrl_a = 0, direction_ctrl_b = 0;
	logic [FAULT_W-1:0] fault_src = '0;
	logic               half_bridge_out_a_hs, half_bridge_out_a_ls, half_bridge_out_b_hs, half_bridge_out_b_ls;
	logic [SLEW_W-1:0]  slew_sel;
	logic               sleep_o, standby_o;
	wire                miso_w = miso_oe ? miso_o : 1'bz;
	// flag line has a pull-up
	wire                fault_flag_n_i = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
	wire [3:0]          sw = {half_bridge_out_a_hs, half_bridge_out_a_ls, half_bridge_out_b_hs, half_bridge_out_b_ls};
	int                 n_errors = 0, check_count = 0, i, k;
	// dir a, dir b, pwm, then a_hs a_ls b_hs b_ls
	logic [6:0]         dir_tab [5] = '{7'h59, 7'h7a, 7'h10, 7'h22, 7'h36};

	hbc_top u_dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
		.sclk_in, .cs_n_in, .mosi_in, .miso_o, .miso_oe, .chip_enable_in, .output_disable_in,
		.direction_ctrl_a, .direction_ctrl_b, .pwm_in, .fault_src, .fault_flag_n_i, .fault_flag_n_o,
		.fault_flag_n_oe, .half_bridge_out_a_hs, .half_bridge_out_a_ls, .half_bridge_out_b_hs,
		.half_bridge_out_b_ls, .slew_sel, .sleep_o, .standby_o
	);
	hbc_spi_master u_mst (.sclk(sclk_in), .cs_n(cs_n_in), .mosi(mosi_in), .miso(miso_w), .pwm(pwm_in));

	always #50 aclk = ~aclk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic give_up();
		n_errors++;
		$display("BAD bus_wait expected answer seen none");
		wrap_up();
	endtask : give_up

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
	endtask : settle

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, er);
		if (k == 50)
			give_up();
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		check("rresp", s_axi_rresp, er);
		if (k == 50)
			give_up();
	endtask : axi_rd

	// no half-bridge ever conducts through both switches
	always @(negedge aclk)
		if (aresetn === 1'b1)
			check("shoot", {sw[3] & sw[2], sw[1] & sw[0]}, 2'h0);

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("sleep", {sleep_o, sw}, 5'h10);
		check("miso_oe", miso_oe, 1'b0);
		axi_wr(AXI_SPI_CFG, 32'h0000_0007, RESP_OKAY);
		axi_rd(AXI_SPI_CFG, rd, RESP_OKAY);
		check("cfg", rd, {2'h0, FMASK_RST, 13'h0, SLEW_RST});
		axi_rd(4'h6, rd, RESP_SLVERR);
		check("unmapped", rd, 32'h0);
		axi_wr(4'h6, 32'h0000_0001, RESP_SLVERR);
		$display("test registers done");
		axi_wr(AXI_IRQ_MASK, 32'h0000_0004, RESP_OKAY);
		direction_ctrl_a <= 1'b1;
		u_mst.set_pwm(1'b1);
		for (i = 0; i < 3; i++)
		begin
			chip_enable_in <= i != 0;
			output_disable_in <= i == 1;
			settle(20);
			axi_rd(AXI_STATUS, rd, RESP_OKAY);
			check("mode", rd[16:14], 3'h1 << i);
			check("sleep_sb", {sleep_o, standby_o}, {i == 0, i == 1});
			check("switches", sw, i == 2 ? 4'h9 : 4'h0);
		end
		check("irq", irq, 1'b1);
		axi_wr(AXI_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
		check("irq_masked", irq, 1'b0);
		axi_wr(AXI_IRQ_MASK, 32'h0000_0004, RESP_OKAY);
		check("irq_unmasked", irq, 1'b1);
		axi_wr(AXI_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
		check("irq_cleared", irq, 1'b0);
		$display("test modes done");
		for (i = 0; i < 5; i++)
		begin
			{direction_ctrl_a, direction_ctrl_b} <= dir_tab[i][6:5];
			u_mst.set_pwm(dir_tab[i][4]);
			settle(20);
			check("direction", sw, dir_tab[i][3:0]);
		end
		$display("test directions done");
		fault_src <= 14'h0002;
		settle(8);
		check("flag", {fault_flag_n_oe, fault_flag_n_i}, 2'h2);
		u_mst.xfer(32'h0000_4005, 16, rx);
		settle(8);
		check("fault_word", rx[15:0], 16'h8002);
		check("slew", slew_sel, 3'h5);
		check("miso_idle", miso_oe, 1'b0);
		u_mst.xfer(32'h4003_8001, 32, rx);
		settle(8);
		check("cfg_read", rx[18:16], 3'h5);
		check("echo", rx[15:0], 16'h4003);
		check("slew_kept", slew_sel, 3'h5);
		check("flag_masked", fault_flag_n_oe, 1'b0);
		u_mst.xfer(32'h0000_0000, 16, rx);
		settle(8);
		check("mask_read", rx[13:0], 14'h0001);
		fault_src <= 14'h0003;
		settle(8);
		check("flag_unmasked", {fault_flag_n_oe, fault_flag_n_i}, 2'h2);
		axi_rd(AXI_IRQ_STAT, rd, RESP_OKAY);
		check("irq_events", rd, 32'h0000_0003);
		$display("test serial done");
		// forward with slew 5: turn-on waits base * (5 + 1) cycles
		{direction_ctrl_a, direction_ctrl_b} <= 2'h2;
		for (k = 0; k < 60 && half_bridge_out_b_hs !== 1'b0; k++)
			@(posedge aclk);
		for (k = 0; k < 60 && half_bridge_out_a_hs !== 1'b1; k++)
			@(posedge aclk);
		check("dead_time", k >= DEAD_BASE_CYC * 6 && k <= DEAD_BASE_CYC * 6 + 2, 1'b1);
		$display("test dead time done");
		wrap_up();
	end
endmodule : test_hbridge_spi_control
